// ===== include/aluf_pkg.sv
// Purpose: constants and operation codes for the arithmetic and flow execution unit
// Assumes: 8-bit data path, 16-bit program counter and register pairs
// Notes:   status byte layout is I T H S V N Z C, carry in bit 0
package aluf_pkg;

   // ---------------------------------------------------------------
   // operation codes
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_CARRY, OP_WORD_IMMEDIATE_SUM,
      OP_SUB, OP_SUBTRACT_IMMEDIATE,
      OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW,
      OP_WORD_IMMEDIATE_DIFFERENCE,
      OP_AND, OP_AND_WITH_IMMEDIATE, OP_OR, OP_OR_WITH_IMMEDIATE, OP_EXCLUSIVE_OR,
      OP_SET_BITS_BY_MASK, OP_CLEAR_BITS_BY_MASK, OP_ZERO_MINUS_TEST,
      OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_BY_UNSIGNED,
      OP_FRACTIONAL_PRODUCT_UNSIGNED, OP_FRACTIONAL_PRODUCT_SIGNED,
      OP_FRACTIONAL_PRODUCT_MIXED,
      OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_JUMP, OP_INDIRECT_CALL,
      OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGISTERS, OP_COMPARE_WITH_CARRY,
      OP_COMPARE_IMMEDIATE, OP_SKIP_IF_REG_BIT_CLEAR
   } aluf_op_e;

   // ---------------------------------------------------------------
   // status byte bit positions
   // ---------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam logic [7:0] SREG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // cycle counts and program counter steps
   // ---------------------------------------------------------------
   localparam logic [1:0] CYC_ONE   = 2'h1;
   localparam logic [1:0] CYC_TWO   = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
   localparam logic [15:0] PC_STEP_THREE = 16'h0003;
   localparam logic [7:0] BYTE_ALL_ONES  = 8'hff;

endpackage

// ===== src/aluf_exec.sv
// Purpose: executes arithmetic, logic, multiply and flow instructions of an 8-bit core
// Assumes: operands come from the register file on the same clock; caller writes back
// Notes:   one instruction in flight; ready is low while a multi-cycle one runs
`timescale 1ns/10ps
`default_nettype none

module aluf_exec (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              start,
   input  wire aluf_pkg::aluf_op_e op,
   input  wire logic [7:0]        opA,
   input  wire logic [7:0]        opB,
   input  wire logic [15:0]       wordIn,
   input  wire logic [5:0]        wordK,
   input  wire logic [7:0]        sregIn,
   input  wire logic [15:0]       pcIn,
   input  wire logic [11:0]       relOffset,
   input  wire logic [15:0]       zPtr,
   input  wire logic [2:0]        bitSel,
   input  wire logic              nextTwoWords,
   output logic                   ready,
   output logic                   done,
   output logic [7:0]             resultQ,
   output logic                   resultWe,
   output logic [15:0]            productQ,
   output logic                   productWe,
   output logic [15:0]            wordQ,
   output logic                   wordWe,
   output logic [7:0]             sregQ,
   output logic [15:0]            pcQ,
   output logic                   pcWe,
   output logic [15:0]            pushAddrQ,
   output logic                   pushWe,
   output logic [1:0]             cyclesQ
);
   import aluf_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // byte add or subtract: returns {h, v, c, result}
   function automatic logic [10:0] addSub(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin, input logic sub);
      logic [8:0] full;
      logic [4:0] low;
      logic       v;
      full = 9'h000;
      low  = 5'h00;
      v    = 1'b0;
      if (sub) begin
         full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
         v    = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
      end else begin
         full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         v    = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
      end
      // bit 8 / bit 4 hold carry on add and borrow on subtract
      return {low[4], v, full[8], full[7:0]};
   endfunction

   // 8x8 multiply with per-operand signedness
   function automatic logic [15:0] mult(input logic [7:0] a, input logic [7:0] b,
                                        input logic aSigned, input logic bSigned);
      logic signed [17:0] pa;
      logic signed [17:0] pb;
      logic signed [17:0] p;
      pa = aSigned ? 18'(signed'(a)) : 18'({1'b0, a});
      pb = bSigned ? 18'(signed'(b)) : 18'({1'b0, b});
      p  = pa * pb;
      return p[15:0];
   endfunction

   // ---------------------------------------------------------------
   // instruction evaluation
   // ---------------------------------------------------------------
   logic        take;
   logic [1:0]  cntQ;
   logic [7:0]  nResult;
   logic        nResultWe;
   logic [15:0] nProduct;
   logic        nProductWe;
   logic [15:0] nWord;
   logic        nWordWe;
   logic [7:0]  nSreg;
   logic [15:0] nPc;
   logic        nPcWe;
   logic        nPushWe;
   logic [1:0]  nCyc;
   logic [10:0] as;
   logic [16:0] wsum;
   logic [15:0] prod;
   logic [15:0] pcRel;
   logic [15:0] skipStep;
   logic [1:0]  skipCyc;

   assign ready = (cntQ == 2'h0);
   assign take  = start & ready;

   // relative target is pc + k + 1 with k sign-extended
   assign pcRel = pcIn + {{4{relOffset[11]}}, relOffset} + PC_STEP_ONE;

   assign skipStep = nextTwoWords ? PC_STEP_THREE : PC_STEP_TWO;
   assign skipCyc  = nextTwoWords ? CYC_THREE : CYC_TWO;

   // decode and compute everything for the offered instruction
   always_comb begin
      nResult    = opA;
      nResultWe  = 1'b0;
      nProduct   = 16'h0000;
      nProductWe = 1'b0;
      nWord      = wordIn;
      nWordWe    = 1'b0;
      nSreg      = sregIn;
      nPc        = pcIn + PC_STEP_ONE;
      nPcWe      = 1'b0;
      nPushWe    = 1'b0;
      nCyc       = CYC_ONE;
      as         = 11'h000;
      wsum       = 17'h00000;
      prod       = 16'h0000;
      case (op)
         OP_ADD, OP_ADD_CARRY: begin
            as = addSub(opA, opB, (op == OP_ADD_CARRY) & sregIn[FLAG_C], 1'b0);
            nResult   = as[7:0];
            nResultWe = 1'b1;
         end
         OP_SUB, OP_SUBTRACT_IMMEDIATE, OP_COMPARE_REGISTERS, OP_COMPARE_IMMEDIATE: begin
            as = addSub(opA, opB, 1'b0, 1'b1);
            nResult = as[7:0];
            nResultWe = (op == OP_SUB) | (op == OP_SUBTRACT_IMMEDIATE);
         end
         OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW,
         OP_COMPARE_WITH_CARRY: begin
            as = addSub(opA, opB, sregIn[FLAG_C], 1'b1);
            nResult   = as[7:0];
            nResultWe = (op != OP_COMPARE_WITH_CARRY);
         end
         OP_WORD_IMMEDIATE_SUM: begin
            wsum    = {1'b0, wordIn} + {11'h000, wordK};
            nWord   = wsum[15:0];
            nWordWe = 1'b1;
            nCyc    = CYC_TWO;
            nSreg[FLAG_C] = wsum[16];
            nSreg[FLAG_V] = ~wordIn[15] & wsum[15];
         end
         OP_WORD_IMMEDIATE_DIFFERENCE: begin
            wsum    = {1'b0, wordIn} - {11'h000, wordK};
            nWord   = wsum[15:0];
            nWordWe = 1'b1;
            nCyc    = CYC_TWO;
            nSreg[FLAG_C] = wsum[16];
            nSreg[FLAG_V] = wordIn[15] & ~wsum[15];
         end
         OP_AND, OP_AND_WITH_IMMEDIATE: begin
            nResult   = opA & opB;
            nResultWe = 1'b1;
         end
         OP_OR, OP_OR_WITH_IMMEDIATE: begin
            nResult   = opA | opB;
            nResultWe = 1'b1;
         end
         OP_EXCLUSIVE_OR: begin
            nResult   = opA ^ opB;
            nResultWe = 1'b1;
         end
         OP_SET_BITS_BY_MASK: begin
            nResult   = opA | opB;
            nResultWe = 1'b1;
         end
         OP_CLEAR_BITS_BY_MASK: begin
            nResult   = opA & (BYTE_ALL_ONES - opB);
            nResultWe = 1'b1;
         end
         OP_ZERO_MINUS_TEST: begin
            nResult   = opA & opA;
            nResultWe = 1'b1;
         end
         OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_BY_UNSIGNED: begin
            prod = mult(opA, opB, op != OP_PRODUCT_UNSIGNED, op == OP_PRODUCT_SIGNED);
            nProduct   = prod;
            nProductWe = 1'b1;
            nCyc       = CYC_TWO;
            nSreg[FLAG_C] = prod[15];
            nSreg[FLAG_Z] = (prod == 16'h0000);
         end
         OP_FRACTIONAL_PRODUCT_UNSIGNED, OP_FRACTIONAL_PRODUCT_SIGNED,
         OP_FRACTIONAL_PRODUCT_MIXED: begin
            prod = mult(opA, opB, op != OP_FRACTIONAL_PRODUCT_UNSIGNED,
                        op == OP_FRACTIONAL_PRODUCT_SIGNED);
            nProduct   = {prod[14:0], 1'b0};
            nProductWe = 1'b1;
            nCyc       = CYC_TWO;
            // carry takes the bit shifted out
            nSreg[FLAG_C] = prod[15];
            nSreg[FLAG_Z] = ({prod[14:0], 1'b0} == 16'h0000);
         end
         OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
            nPc   = pcRel;
            nPcWe = 1'b1;
            nCyc  = (op == OP_RELATIVE_CALL) ? CYC_THREE : CYC_TWO;
            nPushWe = (op == OP_RELATIVE_CALL);
         end
         OP_INDIRECT_JUMP, OP_INDIRECT_CALL: begin
            nPc     = zPtr;
            nPcWe   = 1'b1;
            nCyc    = (op == OP_INDIRECT_CALL) ? CYC_THREE : CYC_TWO;
            nPushWe = (op == OP_INDIRECT_CALL);
         end
         OP_COMPARE_SKIP_EQUAL: begin
            nPcWe = 1'b1;
            if (opA == opB) begin
               nPc  = pcIn + skipStep;
               nCyc = skipCyc;
            end
         end
         OP_SKIP_IF_REG_BIT_CLEAR: begin
            nPcWe = 1'b1;
            if (!opA[bitSel]) begin
               nPc  = pcIn + skipStep;
               nCyc = skipCyc;
            end
         end
         default: begin
            nCyc = CYC_ONE;
         end
      endcase

      // common byte and word flag updates
      case (op)
         OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_IMMEDIATE, OP_DIFFERENCE_WITH_BORROW,
         OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, OP_COMPARE_REGISTERS,
         OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
            nSreg[FLAG_H] = as[10];
            nSreg[FLAG_V] = as[9];
            nSreg[FLAG_C] = as[8];
            nSreg[FLAG_N] = as[7];
            nSreg[FLAG_Z] = (as[7:0] == 8'h00);
         end
         OP_AND, OP_AND_WITH_IMMEDIATE, OP_OR, OP_OR_WITH_IMMEDIATE, OP_EXCLUSIVE_OR,
         OP_SET_BITS_BY_MASK, OP_CLEAR_BITS_BY_MASK, OP_ZERO_MINUS_TEST: begin
            nSreg[FLAG_V] = 1'b0;
            nSreg[FLAG_N] = nResult[7];
            nSreg[FLAG_Z] = (nResult == 8'h00);
         end
         OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE: begin
            nSreg[FLAG_N] = wsum[15];
            nSreg[FLAG_Z] = (wsum[15:0] == 16'h0000);
            nSreg[FLAG_S] = wsum[15] ^ nSreg[FLAG_V];
         end
         default: begin
            nSreg[FLAG_Z] = nSreg[FLAG_Z];
         end
      endcase
   end

   // ---------------------------------------------------------------
   // cycle accounting
   // ---------------------------------------------------------------

   // counts remaining cycles; done marks the end of the last one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cntQ <= 2'h0;
         done <= 1'b0;
      end else if (take) begin
         cntQ <= nCyc - CYC_ONE;
         done <= (nCyc == CYC_ONE);
      end else begin
         if (cntQ != 2'h0) begin
            cntQ <= cntQ - 2'h1;
         end
         done <= (cntQ == 2'h1);
      end
   end

   // ---------------------------------------------------------------
   // result registers
   // ---------------------------------------------------------------

   // data held until the next instruction is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resultQ   <= 8'h00;
         productQ  <= 16'h0000;
         wordQ     <= 16'h0000;
         sregQ     <= SREG_RESET;
         pcQ       <= 16'h0000;
         pushAddrQ <= 16'h0000;
         cyclesQ   <= 2'h0;
      end else if (take) begin
         resultQ   <= nResult;
         productQ  <= nProduct;
         wordQ     <= nWord;
         sregQ     <= nSreg;
         pcQ       <= nPc;
         // return address is the word after the call
         pushAddrQ <= pcIn + PC_STEP_ONE;
         cyclesQ   <= nCyc;
      end
   end

   // write strobes pulse one cycle after take, push in the same cycle as the pc load
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resultWe  <= 1'b0;
         productWe <= 1'b0;
         wordWe    <= 1'b0;
         pcWe      <= 1'b0;
         pushWe    <= 1'b0;
      end else begin
         resultWe  <= take & nResultWe;
         productWe <= take & nProductWe;
         wordWe    <= take & nWordWe;
         pcWe      <= take & nPcWe;
         pushWe    <= take & nPushWe;
      end
   end

endmodule

`default_nettype wire

// ===== tb/aluf_exec_assertions.sv
// Purpose: timing, strobe and flag relations of aluf_exec
// Assumes: one clock domain, nrst asynchronous and active low
// Notes:   watches top module ports only; bound after the module
`timescale 1ns/10ps
`default_nettype none
module aluf_exec_checker (
   input wire logic               clk,
   input wire logic               nrst,
   input wire logic               start,
   input wire aluf_pkg::aluf_op_e op,
   input wire logic [7:0]         opA,
   input wire logic [7:0]         opB,
   input wire logic [7:0]         sregIn,
   input wire logic [15:0]        pcIn,
   input wire logic [15:0]        zPtr,
   input wire logic               nextTwoWords,
   input wire logic               ready,
   input wire logic               done,
   input wire logic               resultWe,
   input wire logic               productWe,
   input wire logic               wordWe,
   input wire logic [7:0]         sregQ,
   input wire logic [15:0]        pcQ,
   input wire logic               pcWe,
   input wire logic [15:0]        pushAddrQ,
   input wire logic               pushWe,
   input wire logic [1:0]         cyclesQ
);
   import aluf_pkg::*;
   logic take;
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   // a take is a start that the idle unit accepts
   assign take = start & ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_add_one_cycle: assert property (
      take && op inside {OP_ADD, OP_ADD_CARRY} |=> done && resultWe && cyclesQ == 2'h1)
      else $error("add not done in one cycle");
   a_word_two_cycle: assert property (
      take && op inside {OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE}
      |=> wordWe && !done && !ready ##1 done)
      else $error("word op not done in two cycles");
   a_sub_one_cycle: assert property (
      take && op inside {[OP_SUB:OP_IMMEDIATE_DIFFERENCE_WITH_BORROW]}
      |=> done && resultWe) else $error("subtract not done in one cycle");
   a_logic_keeps_carry: assert property (
      take && op inside {[OP_AND:OP_ZERO_MINUS_TEST]}
      |=> done && sregQ[FLAG_C] == $past(sregIn[FLAG_C]) && !sregQ[FLAG_V])
      else $error("logic op touched carry or left overflow");
   a_mul_two_cycle: assert property (
      take && op inside {[OP_PRODUCT_UNSIGNED:OP_FRACTIONAL_PRODUCT_MIXED]}
      |=> productWe && !done ##1 done && !productWe)
      else $error("multiply not done in two cycles");
   a_flow_no_flags: assert property (
      take && op inside {[OP_RELATIVE_JUMP:OP_INDIRECT_CALL]}
      |=> pcWe && sregQ == $past(sregIn)) else $error("flow op changed status");
   a_indirect_target: assert property (
      take && op == OP_INDIRECT_JUMP
      |=> pcQ == $past(zPtr) && cyclesQ == 2'h2 ##1 done) else $error("indirect jump wrong");
   a_call_push: assert property (
      take && op inside {OP_RELATIVE_CALL, OP_INDIRECT_CALL}
      |=> pushWe && pushAddrQ == $past(pcIn) + 16'h0001 ##1 !done ##1 done)
      else $error("call push or timing wrong");
   a_skip_long: assert property (
      take && op == OP_COMPARE_SKIP_EQUAL && opA == opB && nextTwoWords
      |=> pcQ == $past(pcIn) + 16'h0003 ##2 done)
      else $error("long skip wrong");
   a_cmp_no_store: assert property (
      take && op inside {[OP_COMPARE_REGISTERS:OP_COMPARE_IMMEDIATE]}
      |=> done && !resultWe) else $error("compare stored result");
   // main scenarios seen at least once
   c_call: cover property (take && op == OP_RELATIVE_CALL);
   c_back_to_back: cover property (done && take);
   c_skip: cover property (take && op == OP_SKIP_IF_REG_BIT_CLEAR);
endmodule
bind aluf_exec aluf_exec_checker u_chk (.clk(clk), .nrst(nrst), .start(start), .op(op),
   .opA(opA), .opB(opB), .sregIn(sregIn), .pcIn(pcIn), .zPtr(zPtr),
   .nextTwoWords(nextTwoWords), .ready(ready), .done(done), .resultWe(resultWe),
   .productWe(productWe), .wordWe(wordWe), .sregQ(sregQ), .pcQ(pcQ), .pcWe(pcWe),
   .pushAddrQ(pushAddrQ), .pushWe(pushWe), .cyclesQ(cyclesQ));
`default_nettype wire

// ===== tb/aluf_exec_tb_top.sv
// Purpose: directed test of every opcode of aluf_exec
// Assumes: inputs change on the falling edge, start held across ops
// Notes:   start stays high so each op after the first since reset is taken in the prior done cycle
`timescale 1ns/10ps
`default_nettype none
module aluf_exec_tb_top;
   import aluf_pkg::*;
   logic        clk, nrst, start, nextTwoWords, ready, done;
   logic        resultWe, productWe, wordWe, pcWe, pushWe;
   aluf_op_e    op;
   logic [7:0]  opA, opB, sregIn, resultQ, sregQ;
   logic [15:0] wordIn, pcIn, zPtr, productQ, wordQ, pcQ, pushAddrQ;
   logic [11:0] relOffset;
   logic [5:0]  wordK;
   logic [2:0]  bitSel;
   logic [1:0]  cyclesQ;
   int          mismatches, compares, ticks;
   aluf_exec dut (.clk(clk), .nrst(nrst), .start(start), .op(op), .opA(opA), .opB(opB),
      .wordIn(wordIn), .wordK(wordK), .sregIn(sregIn), .pcIn(pcIn), .relOffset(relOffset),
      .zPtr(zPtr), .bitSel(bitSel), .nextTwoWords(nextTwoWords), .ready(ready), .done(done),
      .resultQ(resultQ), .resultWe(resultWe), .productQ(productQ), .productWe(productWe),
      .wordQ(wordQ), .wordWe(wordWe), .sregQ(sregQ), .pcQ(pcQ), .pcWe(pcWe),
      .pushAddrQ(pushAddrQ), .pushWe(pushWe), .cyclesQ(cyclesQ));
   // -------------------------------------------------------------
   // clock, hang guard and helpers
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // about 66 cycles expected; ceiling leaves wide margin
   always @(posedge clk) begin
      ticks++;
      if (ticks == 1000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // kind: 0 byte, 1 product, 2 word, 3 pc, 4 nothing stored, 5 pc and push
   task automatic t(input aluf_op_e o, input logic [7:0] a, b, s, input logic [15:0] e,
                    input logic [7:0] es, input logic [1:0] cyc, input int kind);
      int         n;
      logic [4:0] we;
      op = o;
      opA = a;
      opB = b;
      sregIn = s;
      start = 1'b1;
      @(negedge clk);
      n = 1;
      we = {pushWe, pcWe, wordWe, productWe, resultWe};
      while (done !== 1'b1 && n < 5) begin
         @(negedge clk);
         n++;
      end
      chk("cycles", {14'h0000, cyc}, 16'(n));
      chk("cyclesQ", {14'h0000, cyc}, {14'h0000, cyclesQ});
      chk("sregQ", {8'h00, es}, {8'h00, sregQ});
      case (kind)
         0: chk("resultQ", e, {8'h00, resultQ});
         1: chk("productQ", e, productQ);
         2: chk("wordQ", e, wordQ);
         3, 5: chk("pcQ", e, pcQ);
         default: ;
      endcase
      if (kind == 5) chk("pushAddrQ", pcIn + 16'h0001, pushAddrQ);
      chk("strobes", kind == 5 ? 16'h0018 : kind == 4 ? 16'h0000 : 16'h0001 << kind,
          {11'h000, we});
   endtask
   // -------------------------------------------------------------
   // sequence
   // -------------------------------------------------------------
   initial begin
      {nrst, start, nextTwoWords, opA, opB, sregIn, wordIn, wordK} = '0;
      {pcIn, relOffset, zPtr, bitSel, mismatches, compares, ticks} = '0;
      op = OP_ADD;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk("ready", 16'h0001, {15'h0000, ready});
      t(OP_ADD,8'h0f,8'h01,8'h00,16'h0010,8'h20,2'h1,0);
      t(OP_ADD_CARRY,8'hff,8'h00,8'h01,16'h0000,8'h23,2'h1,0);
      wordIn = 16'hffff;
      wordK = 6'h01;
      t(OP_WORD_IMMEDIATE_SUM,8'h00,8'h00,8'h00,16'h0000,8'h03,2'h2,2);
      wordIn = 16'h0000;
      t(OP_WORD_IMMEDIATE_DIFFERENCE,8'h00,8'h00,8'h00,16'hffff,8'h15,2'h2,2);
      t(OP_SUB,8'h80,8'h01,8'h00,16'h007f,8'h28,2'h1,0);
      t(OP_SUBTRACT_IMMEDIATE,8'h05,8'h05,8'h00,16'h0000,8'h02,2'h1,0);
      t(OP_DIFFERENCE_WITH_BORROW,8'h00,8'h00,8'h01,16'h00ff,8'h25,2'h1,0);
      t(OP_IMMEDIATE_DIFFERENCE_WITH_BORROW,8'h10,8'h01,8'h00,16'h000f,8'h20,2'h1,0);
      t(OP_AND,8'hf0,8'h0f,8'h09,16'h0000,8'h03,2'h1,0);
      t(OP_AND_WITH_IMMEDIATE,8'h81,8'h80,8'h00,16'h0080,8'h04,2'h1,0);
      t(OP_OR,8'h00,8'h00,8'h08,16'h0000,8'h02,2'h1,0);
      t(OP_OR_WITH_IMMEDIATE,8'h01,8'h80,8'h01,16'h0081,8'h05,2'h1,0);
      t(OP_EXCLUSIVE_OR,8'hff,8'hff,8'h00,16'h0000,8'h02,2'h1,0);
      t(OP_SET_BITS_BY_MASK,8'h10,8'h03,8'h00,16'h0013,8'h00,2'h1,0);
      t(OP_CLEAR_BITS_BY_MASK,8'hff,8'h0f,8'h00,16'h00f0,8'h04,2'h1,0);
      t(OP_ZERO_MINUS_TEST,8'h80,8'h80,8'h00,16'h0080,8'h04,2'h1,0);
      t(OP_PRODUCT_UNSIGNED,8'hff,8'h02,8'h00,16'h01fe,8'h00,2'h2,1);
      t(OP_PRODUCT_UNSIGNED,8'h00,8'h55,8'h00,16'h0000,8'h02,2'h2,1);
      t(OP_PRODUCT_SIGNED,8'hff,8'h02,8'h00,16'hfffe,8'h01,2'h2,1);
      t(OP_PRODUCT_SIGNED_BY_UNSIGNED,8'hff,8'h02,8'h00,16'hfffe,8'h01,2'h2,1);
      t(OP_FRACTIONAL_PRODUCT_UNSIGNED,8'hff,8'h02,8'h00,16'h03fc,8'h00,2'h2,1);
      t(OP_FRACTIONAL_PRODUCT_SIGNED,8'hff,8'h02,8'h00,16'hfffc,8'h01,2'h2,1);
      t(OP_FRACTIONAL_PRODUCT_MIXED,8'hff,8'h02,8'h00,16'hfffc,8'h01,2'h2,1);
      pcIn = 16'h0100;
      relOffset = 12'h800;
      t(OP_RELATIVE_JUMP,8'h00,8'h00,8'h5a,16'hf901,8'h5a,2'h2,3);
      relOffset = 12'h7ff;
      t(OP_RELATIVE_CALL,8'h00,8'h00,8'h5a,16'h0900,8'h5a,2'h3,5);
      zPtr = 16'hbeef;
      t(OP_INDIRECT_JUMP,8'h00,8'h00,8'h5a,16'hbeef,8'h5a,2'h2,3);
      t(OP_INDIRECT_CALL,8'h00,8'h00,8'h5a,16'hbeef,8'h5a,2'h3,5);
      t(OP_COMPARE_SKIP_EQUAL,8'h3c,8'h3c,8'h5a,16'h0102,8'h5a,2'h2,3);
      nextTwoWords = 1'b1;
      t(OP_COMPARE_SKIP_EQUAL,8'h3c,8'h3c,8'h5a,16'h0103,8'h5a,2'h3,3);
      t(OP_COMPARE_SKIP_EQUAL,8'h3c,8'h3d,8'h5a,16'h0101,8'h5a,2'h1,3);
      bitSel = 3'h3;
      t(OP_SKIP_IF_REG_BIT_CLEAR,8'hf7,8'hf7,8'h5a,16'h0103,8'h5a,2'h3,3);
      bitSel = 3'h0;
      t(OP_SKIP_IF_REG_BIT_CLEAR,8'hf7,8'hf7,8'h5a,16'h0101,8'h5a,2'h1,3);
      t(OP_COMPARE_REGISTERS,8'h05,8'h06,8'h00,16'h0000,8'h25,2'h1,4);
      t(OP_COMPARE_WITH_CARRY,8'h06,8'h05,8'h01,16'h0000,8'h02,2'h1,4);
      t(OP_COMPARE_IMMEDIATE,8'h80,8'h01,8'h00,16'h0000,8'h28,2'h1,4);
      // reset cut into a running call must leave the unit idle and cleared
      op = OP_INDIRECT_CALL;
      @(negedge clk);
      nrst = 1'b0;
      start = 1'b0;
      @(negedge clk);
      chk("rst ready", 16'h0001, {15'h0000, ready});
      chk("rst done", 16'h0000, {15'h0000, done});
      chk("rst pcQ", 16'h0000, pcQ);
      chk("rst words", 16'h0000, productQ | wordQ | pushAddrQ);
      chk("rst bytes", 16'h0000, {resultQ, sregQ});
      chk("rst cyclesQ", 16'h0000, {14'h0000, cyclesQ});
      chk("rst strobes", 16'h0000, {11'h000, pushWe, pcWe, wordWe, productWe, resultWe});
      nrst = 1'b1;
      t(OP_ADD,8'h01,8'h01,8'h00,16'h0002,8'h00,2'h1,0);
      start = 1'b0;
      @(negedge clk);
      close_out();
   end
endmodule
`default_nettype wire
